// ===== verilog/bdm_memory_map.sv
// Function
// - pointer bits 7:6 choose one of four banks
// - indirect access uses pointer low six bits, bank ignored
// - direct access uses opcode low six bits
// - indirect port has no storage, follows pointer
// - special registers only in bank 0, aliased
// - general sram 0x10-0x3f folds onto bank 0
// - f-page and s-page only via own instructions
// - bank bits ignored for f/s-page access
// - f-page decodes 0x6, 0xa, 0xc, 0xf only
// - timer0 read returns live count
// - timer0 write replaces count immediately
// - timer0 source from mode bit and config
// - pc low byte is pc 7:0, resets zero
// - pc advances by one unless held or loaded
// - pc 9:8 from pc high buffer, opcode target or stack
// - short jump: pc 8:0 opcode, bit9 buffer
// - short call: pc 7:0 opcode, push pc+1
// - long jump loads all ten bits
// - long call loads ten bits, pushes pc+1
// - status layout gp, timeout, powerdown, z, dc, c
// - powerdown flag set by wdt clear, cleared sleep
// - timeout flag set by clear/sleep, cleared timeout
// - carry set on carry or no borrow
// - eight-level hardware return stack
`include "bdm_regs.svh"
`default_nettype none
module bdm_memory_map (
    input wire logic ref_clk, // instruction clock
    input wire logic reset_n, // synchronous reset, active low
    input wire bdm_pkg::bdm_space_e acc_space, // space of this access
    input wire logic acc_direct, // 1: direct, 0: via pointer
    input wire logic [5:0] acc_opcode_addr, // opcode file field
    input wire logic acc_rd, // read strobe
    input wire logic acc_wr, // write strobe
    input wire logic [7:0] acc_wdata, // write data
    output logic [7:0] acc_rdata, // read data, combinational mux
    input wire bdm_pkg::bdm_pc_op_e pc_op, // pc update for this cycle
    input wire logic [9:0] instr_target, // target field of instruction
    output logic [9:0] pc, // program counter
    output logic stack_full, // eight return addresses held
    input wire logic alu_flags_wr, // update z, dc, c from alu
    input wire logic alu_zero, // zero result
    input wire logic alu_half_carry, // half carry or no half borrow
    input wire logic alu_carry_out, // carry out of adder
    input wire logic alu_is_sub, // subtraction: carry means no borrow
    input wire logic wdt_clear, // watchdog-clear instruction
    input wire logic sleep_exec, // sleep instruction
    input wire logic wdt_timeout, // watchdog timeout event
    input wire logic t0_mode_bit, // timer0 mode: 1 external pin
    input wire logic cfg_t0_low_osc, // config word: low oscillator
    input wire logic ext_clk_tick, // synchronous external edge
    input wire logic low_osc_tick, // synchronous low-osc edge
    output logic [7:0] pointer_value, // file select pointer
    output logic [7:0] port_direction, // f-page direction register
    output logic [7:0] timer0_prescale, // f-page prescaler control
    output logic [7:0] brownout_ctrl, // f-page brown-out control
    output logic [7:0] power_ctrl_ext, // f-page power control 2
    output logic [7:0] oscillator_ctrl // s-page oscillator control
);
    logic [7:0] status_flags; // status register
    logic [7:0] timer0_count; // live timer0 count
    logic [1:0] pc_high_buffer; // pc 9:8 staging bits
    logic pc_high_buffer_gp; // general bit of the high buffer
    logic [7:0] gpr [`BDM_GPR_FIRST:`BDM_GPR_LAST]; // 48-byte sram
    logic [7:0] sfr_misc [`BDM_R_PORT_B_DATA:`BDM_R_INTFL]; // plain sfr store
    logic [9:0] ret_stack [0:`BDM_STACK_DEPTH-1]; // return addresses
    logic [3:0] sp; // stack fill level
    logic [1:0] bank; // selected bank, only decoded
    logic [5:0] loc; // location within bank
    logic r_wr; // r-page write this cycle
    logic f_wr; // f-page write this cycle
    logic s_wr; // s-page write this cycle
    logic [9:0] pc_plus1; // next sequential address
    logic [9:0] next_pc; // pc after this cycle
    logic t0_tick; // timer0 count enable
    bdm_pkg::bdm_t0_src_e t0_src; // timer0 source

    // address formation; bank decoded even though all banks fold to 0
    always_comb begin
        bank = pointer_value[7:6];
        if (acc_direct && (acc_space != bdm_pkg::BDM_SPACE_R ||
                           acc_opcode_addr != `BDM_R_INDIRECT)) begin
            loc = acc_opcode_addr;
        end else begin
            // the port has no storage, it follows the pointer
            loc = pointer_value[5:0];
        end
    end

    // strobes per space; f/s pages use only the low nibble, no bank
    assign r_wr = acc_wr && acc_space == bdm_pkg::BDM_SPACE_R;
    assign f_wr = acc_wr && acc_space == bdm_pkg::BDM_SPACE_F;
    assign s_wr = acc_wr && acc_space == bdm_pkg::BDM_SPACE_S;

    // read mux; bank bits never enter the decode, so all banks alias
    always_comb begin
        acc_rdata = 8'h00; // empty slots read zero
        case (acc_space)
            bdm_pkg::BDM_SPACE_R: begin
                if (loc >= `BDM_GPR_FIRST) begin
                    acc_rdata = gpr[loc];
                end else begin
                    case (loc)
                        `BDM_R_TIMER0_COUNT: acc_rdata = timer0_count;
                        `BDM_R_PCLOW: acc_rdata = pc[7:0];
                        `BDM_R_STATUS: acc_rdata = status_flags;
                        `BDM_R_FSP: acc_rdata = pointer_value;
                        `BDM_R_PC_HIGH_BUFFER: begin
                            acc_rdata = {5'h00, pc_high_buffer_gp, pc_high_buffer};
                        end
                        `BDM_R_PORT_B_DATA, `BDM_R_POWER_CONTROL, `BDM_R_WAKE,
                        `BDM_R_PULLDN, `BDM_R_PULLUP, `BDM_R_INTEN,
                        `BDM_R_INTFL: acc_rdata = sfr_misc[loc];
                        default: acc_rdata = 8'h00;
                    endcase
                end
            end
            bdm_pkg::BDM_SPACE_F: begin
                case (loc[3:0])
                    `BDM_F_DIR: acc_rdata = port_direction;
                    `BDM_F_T0PS: acc_rdata = timer0_prescale;
                    `BDM_F_BROWN: acc_rdata = brownout_ctrl;
                    `BDM_F_POWER_CONTROL_EXT: acc_rdata = power_ctrl_ext;
                    default: acc_rdata = 8'h00;
                endcase
            end
            bdm_pkg::BDM_SPACE_S: begin
                if (loc[3:0] == `BDM_S_OSC) begin
                    acc_rdata = oscillator_ctrl;
                end
            end
            default: acc_rdata = 8'h00;
        endcase
    end

    // general-purpose sram, one array for all banks
    always_ff @(posedge ref_clk) begin
        if (r_wr && loc >= `BDM_GPR_FIRST) begin
            gpr[loc] <= acc_wdata;
        end
    end

    // plain special registers; their behaviour lives in other blocks
    genvar gi;
    generate
        for (gi = `BDM_R_PORT_B_DATA; gi <= `BDM_R_INTFL; gi++) begin : g_sfr
            always_ff @(posedge ref_clk) begin
                if (!reset_n) begin
                    sfr_misc[gi] <= 8'h00;
                end else if (r_wr && loc == 6'(gi) &&
                             6'(gi) != `BDM_R_PC_HIGH_BUFFER &&
                             6'(gi) != 6'h07 && 6'(gi) != 6'h0d) begin
                    sfr_misc[gi] <= acc_wdata; // unassigned 7, d ignored
                end
            end
        end
    endgenerate

    // file select pointer
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            pointer_value <= 8'h00;
        end else if (r_wr && loc == `BDM_R_FSP) begin
            pointer_value <= acc_wdata;
        end
    end

    // f-page and s-page registers, reached only by their instructions
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            port_direction <= 8'h00;
            timer0_prescale <= 8'h00;
            brownout_ctrl <= 8'h00;
            power_ctrl_ext <= 8'h00;
            oscillator_ctrl <= 8'h00;
        end else begin
            if (f_wr && loc[3:0] == `BDM_F_DIR) begin
                port_direction <= acc_wdata;
            end
            if (f_wr && loc[3:0] == `BDM_F_T0PS) begin
                timer0_prescale <= acc_wdata;
            end
            if (f_wr && loc[3:0] == `BDM_F_BROWN) begin
                brownout_ctrl <= acc_wdata;
            end
            if (f_wr && loc[3:0] == `BDM_F_POWER_CONTROL_EXT) begin
                power_ctrl_ext <= acc_wdata;
            end
            if (s_wr && loc[3:0] == `BDM_S_OSC) begin
                oscillator_ctrl <= acc_wdata;
            end
        end
    end

    // timer0 source: config word picks low osc, else the mode bit
    always_comb begin
        if (cfg_t0_low_osc) begin
            t0_src = bdm_pkg::BDM_T0_LOW;
        end else if (t0_mode_bit) begin
            t0_src = bdm_pkg::BDM_T0_EXT;
        end else begin
            t0_src = bdm_pkg::BDM_T0_INST;
        end
        case (t0_src)
            bdm_pkg::BDM_T0_EXT: t0_tick = ext_clk_tick;
            bdm_pkg::BDM_T0_LOW: t0_tick = low_osc_tick;
            default: t0_tick = 1'b1;
        endcase
    end

    // timer0 count; a write wins over the tick in the same cycle
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            timer0_count <= 8'h00;
        end else if (r_wr && loc == `BDM_R_TIMER0_COUNT) begin
            timer0_count <= acc_wdata;
        end else if (t0_tick) begin
            timer0_count <= timer0_count + 8'h01;
        end
    end

    // pc high buffer, feeds pc 9:8 on pcl write and short call, bit 9 on short jump
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            pc_high_buffer <= 2'b00;
            pc_high_buffer_gp <= 1'b0;
        end else if (r_wr && loc == `BDM_R_PC_HIGH_BUFFER) begin
            pc_high_buffer <= acc_wdata[1:0];
            pc_high_buffer_gp <= acc_wdata[2];
        end
    end

    // next pc selection
    assign pc_plus1 = pc + 10'h001;
    always_comb begin
        case (pc_op)
            bdm_pkg::BDM_PC_HOLD: next_pc = pc;
            bdm_pkg::BDM_PC_SHORT_JUMP: begin
                next_pc = {pc_high_buffer[1], instr_target[8:0]};
            end
            bdm_pkg::BDM_PC_SHORT_CALL: begin
                next_pc = {pc_high_buffer, instr_target[7:0]};
            end
            bdm_pkg::BDM_PC_LONG_JUMP: next_pc = instr_target;
            bdm_pkg::BDM_PC_LONG_CALL: next_pc = instr_target;
            bdm_pkg::BDM_PC_RETURN: begin
                next_pc = (sp != 4'h0) ? ret_stack[3'(sp - 4'h1)] : pc_plus1;
            end
            default: next_pc = pc_plus1;
        endcase
        // a write to the low byte loads pc 7:0 and the buffered high bits
        if (r_wr && loc == `BDM_R_PCLOW) begin
            next_pc = {pc_high_buffer, acc_wdata};
        end
    end

    // program counter register
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            pc <= {2'b00, `BDM_PCL_RST};
        end else begin
            pc <= next_pc;
        end
    end

    // return stack; on overflow the top slot is overwritten, a known limit
    assign stack_full = sp == 4'(`BDM_STACK_DEPTH);
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            sp <= 4'h0;
        end else if (pc_op == bdm_pkg::BDM_PC_SHORT_CALL ||
                     pc_op == bdm_pkg::BDM_PC_LONG_CALL) begin
            ret_stack[3'(stack_full ? 4'h7 : sp)] <= pc_plus1;
            if (!stack_full) begin
                sp <= sp + 4'h1;
            end
        end else if (pc_op == bdm_pkg::BDM_PC_RETURN && sp != 4'h0) begin
            sp <= sp - 4'h1;
        end
    end

    // status flags; hardware events win over a software write
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            status_flags <= `BDM_STATUS_RST;
        end else begin
            if (r_wr && loc == `BDM_R_STATUS) begin
                status_flags <= acc_wdata;
            end
            if (alu_flags_wr) begin
                status_flags[`BDM_ST_Z] <= alu_zero;
                status_flags[`BDM_ST_DC] <= alu_half_carry;
                // subtraction: carry flag means no borrow happened
                status_flags[`BDM_ST_C] <= alu_carry_out;
            end
            if (wdt_clear) begin
                status_flags[`BDM_ST_PD] <= 1'b1;
                status_flags[`BDM_ST_TO] <= 1'b1;
            end else if (sleep_exec) begin
                status_flags[`BDM_ST_PD] <= 1'b0;
                status_flags[`BDM_ST_TO] <= 1'b1;
            end
            if (wdt_timeout) begin
                status_flags[`BDM_ST_TO] <= 1'b0;
            end
        end
    end

    // checks
    chk_pc_step: assert property (@(posedge ref_clk) disable iff (!reset_n)
        pc_op == bdm_pkg::BDM_PC_STEP && !acc_wr |=> pc == $past(pc) + 10'h001)
        else $error("pc did not advance by one");
    chk_short_jump: assert property (@(posedge ref_clk) disable iff (!reset_n)
        pc_op == bdm_pkg::BDM_PC_SHORT_JUMP && !acc_wr |=>
        pc == {$past(pc_high_buffer[1]), $past(instr_target[8:0])})
        else $error("short jump target wrong");
    chk_short_call: assert property (@(posedge ref_clk) disable iff (!reset_n)
        pc_op == bdm_pkg::BDM_PC_SHORT_CALL && !acc_wr |=>
        pc == {$past(pc_high_buffer), $past(instr_target[7:0])})
        else $error("short call target wrong");
    chk_long_jump: assert property (@(posedge ref_clk) disable iff (!reset_n)
        pc_op == bdm_pkg::BDM_PC_LONG_JUMP && !acc_wr |=>
        pc == $past(instr_target))
        else $error("long jump target wrong");
    chk_call_return: assert property (@(posedge ref_clk) disable iff (!reset_n)
        pc_op == bdm_pkg::BDM_PC_LONG_CALL && !acc_wr && !stack_full ##1
        pc_op == bdm_pkg::BDM_PC_RETURN && !acc_wr |=>
        pc == $past(pc, 2) + 10'h001)
        else $error("call did not push pc plus one");
    chk_timer_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
        r_wr && loc == `BDM_R_TIMER0_COUNT |=> timer0_count == $past(acc_wdata))
        else $error("timer0 write not taken");
    chk_sleep_pd: assert property (@(posedge ref_clk) disable iff (!reset_n)
        sleep_exec && !wdt_clear |=> !status_flags[`BDM_ST_PD])
        else $error("sleep did not clear powerdown flag");
    chk_wdt_to: assert property (@(posedge ref_clk) disable iff (!reset_n)
        wdt_timeout |=> !status_flags[`BDM_ST_TO])
        else $error("timeout did not clear flag");
    chk_bank_alias: assert property (@(posedge ref_clk) disable iff (!reset_n)
        acc_space == bdm_pkg::BDM_SPACE_R && acc_direct &&
        acc_opcode_addr == `BDM_R_FSP |-> acc_rdata == pointer_value)
        else $error("pointer read wrong in some bank");
    cov_long_call: cover property (@(posedge ref_clk)
        pc_op == bdm_pkg::BDM_PC_LONG_CALL);
    cov_stack_full: cover property (@(posedge ref_clk) stack_full);
    cov_indirect_gpr: cover property (@(posedge ref_clk)
        acc_rd && !acc_direct && bank == 2'b11 && loc >= `BDM_GPR_FIRST);
endmodule
`default_nettype wire

// ===== common/bdm_regs.svh
`ifndef BDM_REGS_SVH
`define BDM_REGS_SVH
// r-page special-function offsets
`define BDM_R_INDIRECT 6'h00
`define BDM_R_TIMER0_COUNT 6'h01
`define BDM_R_PCLOW 6'h02
`define BDM_R_STATUS 6'h03
`define BDM_R_FSP 6'h04
`define BDM_R_PORT_B_DATA 6'h06
`define BDM_R_POWER_CONTROL 6'h08
`define BDM_R_WAKE 6'h09
`define BDM_R_PC_HIGH_BUFFER 6'h0a
`define BDM_R_PULLDN 6'h0b
`define BDM_R_PULLUP 6'h0c
`define BDM_R_INTEN 6'h0e
`define BDM_R_INTFL 6'h0f
`define BDM_SFR_LAST 6'h0f
`define BDM_GPR_FIRST 6'h10
`define BDM_GPR_LAST 6'h3f
// f-page offsets
`define BDM_F_DIR 4'h6
`define BDM_F_T0PS 4'ha
`define BDM_F_BROWN 4'hc
`define BDM_F_POWER_CONTROL_EXT 4'hf
// s-page offsets
`define BDM_S_OSC 4'hf
// status field positions
`define BDM_ST_TO 4
`define BDM_ST_PD 3
`define BDM_ST_Z 2
`define BDM_ST_DC 1
`define BDM_ST_C 0
// reset values
`define BDM_PCL_RST 8'h00
`define BDM_STATUS_RST 8'h18
`define BDM_STACK_DEPTH 8
`endif

// ===== common/bdm_pkg.sv
`default_nettype none
package bdm_pkg;
    // program-counter update selected by the core for each executed instruction
    typedef enum logic [2:0] {
        BDM_PC_STEP,
        BDM_PC_HOLD,
        BDM_PC_SHORT_JUMP,
        BDM_PC_SHORT_CALL,
        BDM_PC_LONG_JUMP,
        BDM_PC_LONG_CALL,
        BDM_PC_RETURN
    } bdm_pc_op_e;
    // which register space an access targets
    typedef enum logic [1:0] {
        BDM_SPACE_R,
        BDM_SPACE_F,
        BDM_SPACE_S
    } bdm_space_e;
    // timer0 clock source
    typedef enum logic [1:0] {
        BDM_T0_INST,
        BDM_T0_EXT,
        BDM_T0_LOW
    } bdm_t0_src_e;
endpackage
`default_nettype wire

// ===== tb/bdm_core_model.sv
`default_nettype none
// stands in for the core's decode/execute stage: every request is launched
// on a falling edge, so the block samples it cleanly on the next rising one
module bdm_core_model (
    input wire logic ref_clk, // instruction clock
    input wire logic [7:0] acc_rdata, // read data from block
    output var bdm_pkg::bdm_space_e acc_space, // page of access
    output logic acc_direct, // direct or via pointer
    output logic [5:0] acc_opcode_addr, // opcode file field
    output logic acc_rd, // read strobe
    output logic acc_wr, // write strobe
    output logic [7:0] acc_wdata, // write data
    output var bdm_pkg::bdm_pc_op_e pc_op, // pc update
    output logic [9:0] instr_target, // instruction target
    output logic [3:0] alu, // zero, half carry, carry, sub
    output logic [5:0] evt, // one-cycle events
    output logic t0_mode_bit, // timer0 from pin
    output logic cfg_t0_low_osc // timer0 from low osc
);
    // quiet core: pc held so only commanded updates move it
    initial begin
        acc_space = bdm_pkg::BDM_SPACE_R;
        acc_direct = 1'b1;
        acc_opcode_addr = 6'h00;
        acc_rd = 1'b0;
        acc_wr = 1'b0;
        acc_wdata = 8'h00;
        pc_op = bdm_pkg::BDM_PC_HOLD;
        instr_target = 10'h000;
        alu = 4'h0;
        evt = 6'h00;
        t0_mode_bit = 1'b0;
        cfg_t0_low_osc = 1'b0;
    end
    // one write; leading edge wait keeps strobes from two writes apart
    task wr(input bdm_pkg::bdm_space_e s, input logic dr,
            input logic [5:0] a, input logic [7:0] v);
        @(negedge ref_clk);
        acc_space = s;
        acc_direct = dr;
        acc_opcode_addr = a;
        acc_wdata = v;
        acc_rd = 1'b0;
        acc_wr = 1'b1;
        @(negedge ref_clk);
        acc_wr = 1'b0;
    endtask
    // read is combinational, so sample shortly after the fields settle
    task rd(input bdm_pkg::bdm_space_e s, input logic dr,
            input logic [5:0] a, output logic [7:0] d);
        acc_space = s;
        acc_direct = dr;
        acc_opcode_addr = a;
        acc_rd = 1'b1;
        #1 d = acc_rdata;
        // hand back on a falling edge so the next request starts there
        @(negedge ref_clk);
    endtask
    // one executed instruction with the given pc update
    task pc_do(input bdm_pkg::bdm_pc_op_e op, input logic [9:0] t);
        @(negedge ref_clk);
        pc_op = op;
        instr_target = t;
        @(negedge ref_clk);
        pc_op = bdm_pkg::BDM_PC_HOLD;
    endtask
    // event pulses last exactly one rising edge
    task ev(input logic [5:0] e, input logic [3:0] a);
        @(negedge ref_clk);
        evt = e;
        alu = a;
        @(negedge ref_clk);
        evt = 6'h00;
    endtask
    // a call straight followed by a return, no idle cycle between them
    task call_ret(input logic [9:0] t);
        @(negedge ref_clk);
        pc_op = bdm_pkg::BDM_PC_LONG_CALL;
        instr_target = t;
        @(negedge ref_clk);
        pc_op = bdm_pkg::BDM_PC_RETURN;
        @(negedge ref_clk);
        pc_op = bdm_pkg::BDM_PC_HOLD;
    endtask
    // timer0 source levels, changed on a falling edge only
    task t0_source(input logic md, input logic lo);
        @(negedge ref_clk);
        t0_mode_bit = md;
        cfg_t0_low_osc = lo;
    endtask
endmodule
`default_nettype wire

// ===== tb/banked_data_memory_map_tb.sv
`default_nettype none
module banked_data_memory_map_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam bdm_pkg::bdm_space_e SR = bdm_pkg::BDM_SPACE_R;
    localparam bdm_pkg::bdm_space_e SF = bdm_pkg::BDM_SPACE_F;
    localparam bdm_pkg::bdm_space_e SS = bdm_pkg::BDM_SPACE_S;
    logic ref_clk, reset_n; // clock and sync reset
    bdm_pkg::bdm_space_e acc_space; // page
    bdm_pkg::bdm_pc_op_e pc_op; // pc update
    logic acc_direct, acc_rd, acc_wr, stack_full; // access controls
    logic t0_mode_bit, cfg_t0_low_osc; // timer0 source levels
    logic [5:0] acc_opcode_addr, evt; // address field, events
    logic [3:0] alu; // alu result flags
    logic [7:0] acc_wdata, acc_rdata, pointer_value, port_direction;
    logic [7:0] timer0_prescale, brownout_ctrl, power_ctrl_ext;
    logic [7:0] oscillator_ctrl; // s-page register
    logic [9:0] instr_target, pc; // target and program counter
    int fail_count = 0; // mismatches
    int n_checks = 0; // comparisons
    bdm_memory_map dut (.ref_clk, .reset_n, .acc_space, .acc_direct,
        .acc_opcode_addr, .acc_rd, .acc_wr, .acc_wdata, .acc_rdata,
        .pc_op, .instr_target, .pc, .stack_full,
        .alu_flags_wr(evt[5]), .alu_zero(alu[3]), .alu_half_carry(alu[2]),
        .alu_carry_out(alu[1]), .alu_is_sub(alu[0]), .wdt_clear(evt[4]),
        .sleep_exec(evt[3]), .wdt_timeout(evt[2]), .t0_mode_bit,
        .cfg_t0_low_osc, .ext_clk_tick(evt[1]), .low_osc_tick(evt[0]),
        .pointer_value, .port_direction, .timer0_prescale, .brownout_ctrl,
        .power_ctrl_ext, .oscillator_ctrl);
    bdm_core_model m (.ref_clk, .acc_rdata, .acc_space, .acc_direct,
        .acc_opcode_addr, .acc_rd, .acc_wr, .acc_wdata, .pc_op,
        .instr_target, .alu, .evt, .t0_mode_bit, .cfg_t0_low_osc);
    // 4 ns period
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    task chk8(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
            fail_count++;
        end
    endtask
    task chk10(input logic [9:0] g, input logic [9:0] e);
        n_checks++;
        if (g !== e) begin
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
            fail_count++;
        end
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // flags walk through alu, sleep, timeout and clear events
    task t_status;
        logic [7:0] d;
        m.rd(SR, 1'b1, 6'h03, d);
        chk8(d, 8'h18);
        m.ev(6'h20, 4'h3);
        m.rd(SR, 1'b1, 6'h03, d);
        chk8(d, 8'h19);
        m.ev(6'h20, 4'ha);
        m.ev(6'h08, 4'ha);
        m.rd(SR, 1'b1, 6'h03, d);
        chk8(d, 8'h15);
        m.ev(6'h04, 4'ha);
        m.rd(SR, 1'b1, 6'h03, d);
        chk8(d, 8'h05);
        m.ev(6'h10, 4'ha);
        m.rd(SR, 1'b1, 6'h03, d);
        chk8(d, 8'h1d);
        m.wr(SR, 1'b1, 6'h03, 8'hfd);
        m.rd(SR, 1'b1, 6'h03, d);
        chk8(d, 8'hfd);
    endtask
    // banks fold onto bank 0; pointer port has no storage
    task t_banks;
        logic [7:0] d;
        logic [5:0] rz [3] = '{6'h05, 6'h07, 6'h0d};
        m.wr(SR, 1'b1, 6'h20, 8'h5a);
        m.wr(SR, 1'b1, 6'h04, 8'hc0);
        chk8(pointer_value, 8'hc0);
        m.rd(SR, 1'b1, 6'h20, d);
        chk8(d, 8'h5a);
        m.wr(SR, 1'b1, 6'h04, 8'h65);
        m.wr(SR, 1'b0, 6'h00, 8'ha3);
        m.rd(SR, 1'b1, 6'h25, d);
        chk8(d, 8'ha3);
        m.rd(SR, 1'b1, 6'h00, d);
        chk8(d, 8'ha3);
        m.wr(SR, 1'b1, 6'h04, 8'h80);
        m.wr(SR, 1'b1, 6'h0a, 8'h05);
        m.wr(SR, 1'b1, 6'h04, 8'h00);
        m.rd(SR, 1'b1, 6'h0a, d);
        chk8(d & 8'h07, 8'h05);
        for (int i = 0; i < 3; i++) begin
            m.wr(SR, 1'b1, rz[i], 8'hff);
            m.rd(SR, 1'b1, rz[i], d);
            chk8(d, 8'h00);
        end
    endtask
    // f and s pages: own decode, bank bits set high to show they are ignored
    task t_pages;
        logic [7:0] d, e;
        m.wr(SR, 1'b1, 6'h04, 8'hc0);
        for (int i = 0; i < 16; i++) m.wr(SF, 1'b1, 6'(i), 8'h80 | 8'(i));
        for (int i = 0; i < 16; i++) begin
            e = (i == 6 || i == 10 || i == 12 || i == 15) ?
                8'h80 | 8'(i) : 8'h00;
            m.rd(SF, 1'b1, 6'(i), d);
            chk8(d, e);
        end
        chk8(port_direction, 8'h86);
        chk8(timer0_prescale, 8'h8a);
        m.wr(SR, 1'b1, 6'h0c, 8'h11);
        m.wr(SR, 1'b1, 6'h0f, 8'h00);
        m.wr(SS, 1'b1, 6'h0f, 8'h5e);
        m.wr(SS, 1'b1, 6'h03, 8'h77);
        chk8(brownout_ctrl, 8'h8c);
        chk8(power_ctrl_ext, 8'h8f);
        chk8(oscillator_ctrl, 8'h5e);
        m.rd(SS, 1'b1, 6'h03, d);
        chk8(d, 8'h00);
    endtask
    // live count, write takes over at once, each source in turn
    task t_timer;
        logic [7:0] d;
        m.wr(SR, 1'b1, 6'h01, 8'hff);
        m.rd(SR, 1'b1, 6'h01, d);
        chk8(d, 8'hff);
        m.rd(SR, 1'b1, 6'h01, d);
        chk8(d, 8'h00);
        m.t0_source(1'b1, 1'b0);
        m.wr(SR, 1'b1, 6'h01, 8'h10);
        @(negedge ref_clk);
        m.rd(SR, 1'b1, 6'h01, d);
        chk8(d, 8'h10);
        m.ev(6'h02, 4'h0);
        m.rd(SR, 1'b1, 6'h01, d);
        chk8(d, 8'h11);
        m.t0_source(1'b1, 1'b1);
        m.ev(6'h02, 4'h0);
        m.ev(6'h01, 4'h0);
        m.rd(SR, 1'b1, 6'h01, d);
        chk8(d, 8'h12);
    endtask
    // jump and call forms, high bits from the buffer or the long target
    task t_pc;
        logic [7:0] d;
        chk10(pc, 10'h000);
        m.pc_do(bdm_pkg::BDM_PC_STEP, 10'h000);
        m.pc_do(bdm_pkg::BDM_PC_STEP, 10'h000);
        chk10(pc, 10'h002);
        m.wr(SR, 1'b1, 6'h0a, 8'h02);
        m.pc_do(bdm_pkg::BDM_PC_SHORT_JUMP, 10'h1a5);
        chk10(pc, 10'h3a5);
        m.rd(SR, 1'b1, 6'h02, d);
        chk8(d, 8'ha5);
        m.wr(SR, 1'b1, 6'h0a, 8'h01);
        m.pc_do(bdm_pkg::BDM_PC_SHORT_CALL, 10'h2c4);
        chk10(pc, 10'h1c4);
        m.pc_do(bdm_pkg::BDM_PC_RETURN, 10'h000);
        chk10(pc, 10'h3a6);
        m.pc_do(bdm_pkg::BDM_PC_LONG_JUMP, 10'h155);
        chk10(pc, 10'h155);
        m.pc_do(bdm_pkg::BDM_PC_LONG_CALL, 10'h2e3);
        chk10(pc, 10'h2e3);
        m.pc_do(bdm_pkg::BDM_PC_RETURN, 10'h000);
        chk10(pc, 10'h156);
        m.call_ret(10'h2e3);
        chk10(pc, 10'h157);
        m.wr(SR, 1'b1, 6'h02, 8'h77);
        chk10(pc, 10'h177);
    endtask
    // eight nested calls fill the stack, unwound in reverse
    task t_stack;
        for (int i = 0; i < 8; i++) begin
            chk10({9'h000, stack_full}, 10'h000);
            m.pc_do(bdm_pkg::BDM_PC_LONG_CALL, 10'(i));
        end
        chk10({9'h000, stack_full}, 10'h001);
        for (int i = 7; i > 0; i--) begin
            m.pc_do(bdm_pkg::BDM_PC_RETURN, 10'h000);
            chk10(pc, 10'(i));
        end
        m.pc_do(bdm_pkg::BDM_PC_RETURN, 10'h000);
        chk10(pc, 10'h178);
    endtask
    // main sequence; the pc test needs the pc untouched since reset
    initial begin
        reset_n = 1'b0;
        repeat (2) @(negedge ref_clk);
        reset_n = 1'b1;
        chk8(pointer_value, 8'h00);
        t_pc();
        t_stack();
        t_status();
        t_banks();
        t_pages();
        t_timer();
        report_and_stop();
    end
    // the run needs well under a thousand cycles
    initial begin
        #20000;
        fail_count++;
        report_and_stop();
    end
endmodule
`default_nettype wire
